// *** design/rximd_top.sv ***
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Mode 00 rise, 01 fall, 10 level
// - Validity error source has two-bit mode field
// - Output-one selector in bits 3:0, upper zero
// - Code 0000 low by default, 0001 high
// - Code 0011 drives transmitter irq, active low
// - Code 0100 drives receiver irq, active low
// - Code 0101 low while 50/15 pre-emphasis
// - Code 0110 high on non-audio data
// - Code 0111 high on not-valid data
// - Code 1000 routes channel status bit
// - Code 1001 routes user data bit
// - Code 1010 routes block start clock
// - Code 1011 routes copy bit
// - Code 1100 routes generation-status bit
// - Code 1101 high on parity error
// - Code 1110 routes receiver sync clock
// - Code 1111 routes transmitter sync clock
module rximd_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [5:0] rx_event_in,
	input wire logic [11:0] gpo_src_in,
	output logic rx_irq,
	output logic gp_output_one
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [1:0] buffer_xfer_irq_mode_r, buffer_xfer_irq_mode_nxt;
	logic [7:0] mode_two_r, mode_two_nxt;
	logic [1:0] out_slip_irq_mode_r, out_slip_irq_mode_nxt;
	logic [3:0] gp_output_one_sel_r, gp_output_one_sel_nxt;
	logic [5:0] stat_r, stat_nxt;
	logic [5:0] mask_r, mask_nxt;
	logic irq_r, irq_nxt;
	logic gpo_r, gpo_nxt;
	logic [11:0] g1_r, g1_nxt;
	logic [11:0] g2_r, g2_nxt;

	// Bus state
	logic aw_held_r, aw_held_nxt;
	logic [5:0] aw_idx_r, aw_idx_nxt;
	logic w_held_r, w_held_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	logic aw_fire, w_fire, ar_fire, wr_do;
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic [7:0] wr_byte;
	logic wr_en;
	logic [5:0] stat_clr;
	logic [5:0] src_evt;
	logic [1:0] src_mode [6];
	logic [7:0] rd_val;
	logic rd_ok;

	// ----------------------------------------
	// Per-source trigger detection
	// ----------------------------------------
	rximd_trig_if tif [6] ();

	assign src_mode[rximd_pkg::SRC_BUF] = buffer_xfer_irq_mode_r;
	assign src_mode[rximd_pkg::SRC_CS_CRC] = mode_two_r[rximd_pkg::CS_CRC_LSB +: 2];
	assign src_mode[rximd_pkg::SRC_PARITY] = mode_two_r[rximd_pkg::PARITY_LSB +: 2];
	assign src_mode[rximd_pkg::SRC_VALIDITY] = mode_two_r[rximd_pkg::VALIDITY_LSB +: 2];
	assign src_mode[rximd_pkg::SRC_BIPHASE] = mode_two_r[rximd_pkg::BIPHASE_LSB +: 2];
	assign src_mode[rximd_pkg::SRC_SLIP] = out_slip_irq_mode_r;

	for (genvar i = 0; i < rximd_pkg::N_SRC; i++) begin : g_src
		assign tif[i].raw = rx_event_in[i];
		assign tif[i].mode = src_mode[i];
		assign src_evt[i] = tif[i].evt;
		rximd_trig u_trig (
			.aclk(aclk),
			.aresetn(aresetn),
			.tp(tif[i])
		);
	end

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	// One write in flight; address and data taken in either order
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign wr_do = (aw_held_r || aw_fire) && (w_held_r || w_fire);
	assign wr_idx = aw_held_r ? aw_idx_r : s_axi_awaddr[7:2];
	assign wr_byte = w_held_r ? wdata_r : s_axi_wdata[7:0];
	assign wr_en = wr_do && (w_held_r ? wstrb_r : s_axi_wstrb[0]);

	always_comb begin
		aw_held_nxt = aw_held_r;
		aw_idx_nxt = aw_idx_r;
		w_held_nxt = w_held_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_fire) begin
			aw_held_nxt = 1'b1;
			aw_idx_nxt = s_axi_awaddr[7:2];
		end
		if (w_fire) begin
			w_held_nxt = 1'b1;
			wdata_nxt = s_axi_wdata[7:0];
			wstrb_nxt = s_axi_wstrb[0];
		end
		if (wr_do) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			if (wr_idx == rximd_pkg::IDX_MODE_ONE || wr_idx == rximd_pkg::IDX_MODE_TWO ||
				wr_idx == rximd_pkg::IDX_MODE_THREE || wr_idx == rximd_pkg::IDX_GPO_ONE ||
				wr_idx == rximd_pkg::IDX_IRQ_STAT || wr_idx == rximd_pkg::IDX_IRQ_MASK) begin
				bresp_nxt = rximd_pkg::RESP_OKAY;
			end else begin
				bresp_nxt = rximd_pkg::RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// Register file updates
	// ----------------------------------------
	always_comb begin
		buffer_xfer_irq_mode_nxt = buffer_xfer_irq_mode_r;
		mode_two_nxt = mode_two_r;
		out_slip_irq_mode_nxt = out_slip_irq_mode_r;
		gp_output_one_sel_nxt = gp_output_one_sel_r;
		mask_nxt = mask_r;
		stat_clr = 6'h00;
		if (wr_en) begin
			if (wr_idx == rximd_pkg::IDX_MODE_ONE) begin
				buffer_xfer_irq_mode_nxt = wr_byte[1:0];
			end else if (wr_idx == rximd_pkg::IDX_MODE_TWO) begin
				mode_two_nxt = wr_byte;
			end else if (wr_idx == rximd_pkg::IDX_MODE_THREE) begin
				out_slip_irq_mode_nxt = wr_byte[1:0];
			end else if (wr_idx == rximd_pkg::IDX_GPO_ONE) begin
				gp_output_one_sel_nxt = wr_byte[3:0];
			end else if (wr_idx == rximd_pkg::IDX_IRQ_STAT) begin
				stat_clr = wr_byte[5:0];
			end else if (wr_idx == rximd_pkg::IDX_IRQ_MASK) begin
				mask_nxt = wr_byte[5:0];
			end
		end
		// New event beats a simultaneous clear so nothing is lost
		stat_nxt = (stat_r & ~stat_clr) | src_evt;
		irq_nxt = |(stat_nxt & mask_nxt);
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign s_axi_arready = !rvalid_r;
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign rd_idx = s_axi_araddr[7:2];

	always_comb begin
		rd_ok = 1'b1;
		rd_val = 8'h00;
		if (rd_idx == rximd_pkg::IDX_MODE_ONE) begin
			rd_val = {6'h00, buffer_xfer_irq_mode_r};
		end else if (rd_idx == rximd_pkg::IDX_MODE_TWO) begin
			rd_val = mode_two_r;
		end else if (rd_idx == rximd_pkg::IDX_MODE_THREE) begin
			rd_val = {6'h00, out_slip_irq_mode_r};
		end else if (rd_idx == rximd_pkg::IDX_GPO_ONE) begin
			rd_val = {4'h0, gp_output_one_sel_r};
		end else if (rd_idx == rximd_pkg::IDX_IRQ_STAT) begin
			rd_val = {2'h0, stat_r};
		end else if (rd_idx == rximd_pkg::IDX_IRQ_MASK) begin
			rd_val = {2'h0, mask_r};
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (ar_fire) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = {24'h000000, rd_val};
			rresp_nxt = rd_ok ? rximd_pkg::RESP_OKAY : rximd_pkg::RESP_SLVERR;
		end
	end

	// ----------------------------------------
	// Output-one source selection
	// ----------------------------------------
	// Pin-side sources pass two flops before the selector
	assign g1_nxt = gpo_src_in;
	assign g2_nxt = g1_r;

	always_comb begin
		case (gp_output_one_sel_r)
			rximd_pkg::SEL_HIGH: gpo_nxt = 1'b1;
			rximd_pkg::SEL_TX_IRQ: gpo_nxt = !g2_r[rximd_pkg::G_TX_IRQ];
			rximd_pkg::SEL_RX_IRQ: gpo_nxt = !irq_r;
			rximd_pkg::SEL_PREEMPH: gpo_nxt = !g2_r[rximd_pkg::G_PREEMPH];
			rximd_pkg::SEL_NON_AUDIO: gpo_nxt = g2_r[rximd_pkg::G_NON_AUDIO];
			rximd_pkg::SEL_NOT_VALID: gpo_nxt = g2_r[rximd_pkg::G_NOT_VALID];
			rximd_pkg::SEL_CS_BIT: gpo_nxt = g2_r[rximd_pkg::G_CS_BIT];
			rximd_pkg::SEL_USER_BIT: gpo_nxt = g2_r[rximd_pkg::G_USER_BIT];
			rximd_pkg::SEL_BLK_START: gpo_nxt = g2_r[rximd_pkg::G_BLK_START];
			rximd_pkg::SEL_COPY_BIT: gpo_nxt = g2_r[rximd_pkg::G_COPY_BIT];
			rximd_pkg::SEL_GEN_BIT: gpo_nxt = g2_r[rximd_pkg::G_GEN_BIT];
			rximd_pkg::SEL_PARITY_ERR: gpo_nxt = g2_r[rximd_pkg::G_PARITY_ERR];
			rximd_pkg::SEL_RX_SYNC: gpo_nxt = g2_r[rximd_pkg::G_RX_SYNC];
			rximd_pkg::SEL_TX_SYNC: gpo_nxt = g2_r[rximd_pkg::G_TX_SYNC];
			default: gpo_nxt = 1'b0;
		endcase
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buffer_xfer_irq_mode_r <= rximd_pkg::MODE_FIELD_RST;
			mode_two_r <= rximd_pkg::MODE_TWO_RST;
			out_slip_irq_mode_r <= rximd_pkg::MODE_FIELD_RST;
			gp_output_one_sel_r <= rximd_pkg::GPO_SEL_RST;
			stat_r <= rximd_pkg::IRQ_VEC_RST;
			mask_r <= rximd_pkg::IRQ_VEC_RST;
			irq_r <= 1'b0;
			gpo_r <= 1'b0;
			g1_r <= 12'h000;
			g2_r <= 12'h000;
			aw_held_r <= 1'b0;
			aw_idx_r <= 6'h00;
			w_held_r <= 1'b0;
			wdata_r <= 8'h00;
			wstrb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= rximd_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= rximd_pkg::RESP_OKAY;
		end else begin
			buffer_xfer_irq_mode_r <= buffer_xfer_irq_mode_nxt;
			mode_two_r <= mode_two_nxt;
			out_slip_irq_mode_r <= out_slip_irq_mode_nxt;
			gp_output_one_sel_r <= gp_output_one_sel_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
			gpo_r <= gpo_nxt;
			g1_r <= g1_nxt;
			g2_r <= g2_nxt;
			aw_held_r <= aw_held_nxt;
			aw_idx_r <= aw_idx_nxt;
			w_held_r <= w_held_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign rx_irq = irq_r;
	assign gp_output_one = gpo_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_gpo_forced_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_output_one_sel_r == rximd_pkg::SEL_LOW) |=> !gp_output_one)
		else $error("output one not forced low");
	chk_gpo_forced_high: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_output_one_sel_r == rximd_pkg::SEL_HIGH) |=> gp_output_one)
		else $error("output one not forced high");
	chk_gpo_tx_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_output_one_sel_r == rximd_pkg::SEL_TX_IRQ) |=>
		(gp_output_one == !$past(g2_r[rximd_pkg::G_TX_IRQ])))
		else $error("transmitter irq not inverted on output one");
	chk_gpo_rx_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_output_one_sel_r == rximd_pkg::SEL_RX_IRQ) |=> (gp_output_one == !$past(rx_irq)))
		else $error("receiver irq not inverted on output one");
	chk_gpo_preemph: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_output_one_sel_r == rximd_pkg::SEL_PREEMPH) |=>
		(gp_output_one == !$past(g2_r[rximd_pkg::G_PREEMPH])))
		else $error("pre-emphasis not active low");
	chk_gpo_parity: assert property (@(posedge aclk) disable iff (!aresetn)
		(gp_output_one_sel_r == rximd_pkg::SEL_PARITY_ERR) |=>
		(gp_output_one == $past(g2_r[rximd_pkg::G_PARITY_ERR])))
		else $error("parity error not routed");
	chk_mode_two_write: assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_en && wr_idx == rximd_pkg::IDX_MODE_TWO) |=> (mode_two_r == $past(wr_byte)))
		else $error("mode two write lost");
	chk_sel_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_fire && rd_idx == rximd_pkg::IDX_GPO_ONE) |=>
		(s_axi_rvalid && s_axi_rdata[31:4] == 28'h0000000))
		else $error("selector upper bits not zero");
	chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_irq == |(stat_r & mask_r))
		else $error("irq output disagrees with status");
	chk_resp_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_do |=> s_axi_bvalid)
		else $error("write response missing");

endmodule : rximd_top

// *** shared/rximd_pkg.sv ***
package rximd_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	localparam logic [5:0] IDX_MODE_ONE = 6'h18;
	localparam logic [5:0] IDX_MODE_TWO = 6'h19;
	localparam logic [5:0] IDX_MODE_THREE = 6'h1a;
	localparam logic [5:0] IDX_GPO_ONE = 6'h1b;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h30;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h31;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] MODE_FIELD_RST = 2'h0;
	localparam logic [7:0] MODE_TWO_RST = 8'h00;
	localparam logic [3:0] GPO_SEL_RST = 4'h0;
	localparam logic [5:0] IRQ_VEC_RST = 6'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CS_CRC_LSB = 6;
	localparam int PARITY_LSB = 4;
	localparam int VALIDITY_LSB = 2;
	localparam int BIPHASE_LSB = 0;
	localparam int N_SRC = 6;
	localparam int SRC_BUF = 0;
	localparam int SRC_CS_CRC = 1;
	localparam int SRC_PARITY = 2;
	localparam int SRC_VALIDITY = 3;
	localparam int SRC_BIPHASE = 4;
	localparam int SRC_SLIP = 5;

	// Output-one source inputs
	localparam int N_GSRC = 12;
	localparam int G_TX_IRQ = 0;
	localparam int G_PREEMPH = 1;
	localparam int G_NON_AUDIO = 2;
	localparam int G_NOT_VALID = 3;
	localparam int G_CS_BIT = 4;
	localparam int G_USER_BIT = 5;
	localparam int G_BLK_START = 6;
	localparam int G_COPY_BIT = 7;
	localparam int G_GEN_BIT = 8;
	localparam int G_PARITY_ERR = 9;
	localparam int G_RX_SYNC = 10;
	localparam int G_TX_SYNC = 11;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_RISE = 2'h0,
		MODE_FALL = 2'h1,
		MODE_LEVEL = 2'h2,
		MODE_RSVD = 2'h3
	} rximd_mode_e;

	typedef enum logic [3:0] {
		SEL_LOW = 4'h0,
		SEL_HIGH = 4'h1,
		SEL_RSVD = 4'h2,
		SEL_TX_IRQ = 4'h3,
		SEL_RX_IRQ = 4'h4,
		SEL_PREEMPH = 4'h5,
		SEL_NON_AUDIO = 4'h6,
		SEL_NOT_VALID = 4'h7,
		SEL_CS_BIT = 4'h8,
		SEL_USER_BIT = 4'h9,
		SEL_BLK_START = 4'ha,
		SEL_COPY_BIT = 4'hb,
		SEL_GEN_BIT = 4'hc,
		SEL_PARITY_ERR = 4'hd,
		SEL_RX_SYNC = 4'he,
		SEL_TX_SYNC = 4'hf
	} rximd_sel_e;

endpackage : rximd_pkg

// *** shared/rximd_trig_if.sv ***
`timescale 1ns/1ps
interface rximd_trig_if;
	logic raw;
	logic [1:0] mode;
	logic evt;
	modport det (input raw, input mode, output evt);
	modport ctl (output raw, output mode, input evt);
endinterface : rximd_trig_if

// *** design/rximd_trig.sv ***
`timescale 1ns/1ps
module rximd_trig (
	input wire logic aclk,
	input wire logic aresetn,
	rximd_trig_if.det tp
);
	logic s1_r, s1_nxt;
	logic s2_r, s2_nxt;
	logic prev_r, prev_nxt;

	// ----------------------------------------
	// Synchroniser and edge history
	// ----------------------------------------
	always_comb begin
		s1_nxt = tp.raw;
		s2_nxt = s1_r;
		prev_nxt = s2_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			prev_r <= prev_nxt;
		end
	end

	// Reserved code falls back to the rising-edge default
	always_comb begin
		case (tp.mode)
			rximd_pkg::MODE_FALL: tp.evt = !s2_r && prev_r;
			rximd_pkg::MODE_LEVEL: tp.evt = s2_r;
			default: tp.evt = s2_r && !prev_r;
		endcase
	end

	chk_rise_event: assert property (@(posedge aclk) disable iff (!aresetn)
		(tp.mode == rximd_pkg::MODE_RISE && $rose(s2_r)) |-> tp.evt)
		else $error("rising edge missed");
	chk_fall_event: assert property (@(posedge aclk) disable iff (!aresetn)
		(tp.mode == rximd_pkg::MODE_FALL) |-> (tp.evt == $fell(s2_r)))
		else $error("falling edge mode wrong");
	chk_level_event: assert property (@(posedge aclk) disable iff (!aresetn)
		(tp.mode == rximd_pkg::MODE_LEVEL) |-> (tp.evt == s2_r))
		else $error("level mode wrong");

endmodule : rximd_trig

// *** verification/rximd_far.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Far-side source logic
// ----------------------------------------
module rximd_far (
	input wire logic aclk,
	output logic [5:0] rx_event_in,
	output logic [11:0] gpo_src_in
);
	// Levels change just after an edge, as a free-running source would
	initial begin
		rx_event_in = 6'h00;
		gpo_src_in = 12'h000;
	end
	task automatic set_ev(input logic [5:0] v);
		@(posedge aclk);
		rx_event_in <= v;
	endtask : set_ev
	task automatic set_src(input logic [11:0] v);
		@(posedge aclk);
		gpo_src_in <= v;
	endtask : set_src
endmodule : rximd_far

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic aclk, aresetn, rx_irq, gp_output_one;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb;
	logic [5:0] rx_event_in;
	logic [11:0] gpo_src_in;
	int n_mismatch = 0;
	int tests_run = 0;

	rximd_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_event_in,
		.gpo_src_in, .rx_irq, .gp_output_one);
	rximd_far FAR (.aclk, .rx_event_in, .gpo_src_in);

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic stop_test();
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic lim(inout int n);
		@(negedge aclk);
		n++;
		if (n > 40) begin
			n_mismatch++;
			$display("BAD %0t bus wait ran out", $time);
			stop_test();
		end
	endtask : lim

	task automatic wr(input logic [5:0] idx, input logic [7:0] d,
		input logic [1:0] er = rximd_pkg::RESP_OKAY, input logic [3:0] st = 4'h1);
		int n;
		bit ga, gb, a, b;
		n = 0;
		ga = 1'b0;
		gb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Address and data may be taken at different edges
		while (!(ga && gb)) begin
			lim(n);
			a = s_axi_awvalid & s_axi_awready;
			b = s_axi_wvalid & s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= s_axi_awvalid & ~a;
			s_axi_wvalid <= s_axi_wvalid & ~b;
			ga = ga | a;
			gb = gb | b;
		end
		do lim(n); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [7:0] ed,
		input logic [1:0] er = rximd_pkg::RESP_OKAY);
		int n;
		bit a;
		n = 0;
		a = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!a) begin
			lim(n);
			a = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 1'b0;
		do lim(n); while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rresp, er);
		if (er === rximd_pkg::RESP_OKAY) begin
			chk(s_axi_rdata, {24'h0, ed});
		end
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic irq_is(input logic e);
		int n;
		n = 0;
		while (rx_irq !== e && n < 8) begin
			@(negedge aclk);
			n++;
		end
		chk(rx_irq, e);
	endtask : irq_is

	function automatic logic [11:0] hot(input int c);
		return 12'h001 << ((c == 3) ? 0 : (c == 5) ? 1 : (c > 5) ? c - 4 : 0);
	endfunction : hot

	function automatic logic pin_exp(input int c, input logic v);
		return (c == 1) ? 1'b1 : (c == 0 || c == 2) ? 1'b0 : (c == 3 || c == 5) ? !v : v;
	endfunction : pin_exp

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		@(negedge aclk);
		chk(gp_output_one, 1'b0);
		chk(rx_irq, 1'b0);
		rd(rximd_pkg::IDX_MODE_TWO, 8'h00);
		rd(rximd_pkg::IDX_MODE_THREE, 8'h00);
		rd(rximd_pkg::IDX_GPO_ONE, 8'h00);
		rd(6'h3f, 8'h00, rximd_pkg::RESP_SLVERR);
		wr(6'h3e, 8'hff, rximd_pkg::RESP_SLVERR);
	endtask : t_reset

	task automatic t_regs();
		wr(rximd_pkg::IDX_MODE_TWO, 8'hff);
		rd(rximd_pkg::IDX_MODE_TWO, 8'hff);
		wr(rximd_pkg::IDX_MODE_THREE, 8'hff);
		rd(rximd_pkg::IDX_MODE_THREE, 8'h03);
		wr(rximd_pkg::IDX_GPO_ONE, 8'hff);
		rd(rximd_pkg::IDX_GPO_ONE, 8'h0f);
		// Lane zero off: the bus answers but the register keeps its value
		wr(rximd_pkg::IDX_GPO_ONE, 8'h00, rximd_pkg::RESP_OKAY, 4'he);
		rd(rximd_pkg::IDX_GPO_ONE, 8'h0f);
		wr(rximd_pkg::IDX_MODE_ONE, 8'hff);
		rd(rximd_pkg::IDX_MODE_ONE, 8'h03);
		wr(rximd_pkg::IDX_MODE_ONE, 8'h00);
		wr(rximd_pkg::IDX_MODE_TWO, 8'h00);
		wr(rximd_pkg::IDX_MODE_THREE, 8'h00);
		wr(rximd_pkg::IDX_GPO_ONE, 8'h00);
	endtask : t_regs

	// Level mode re-arms while the source is still high after a clear
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			wr(rximd_pkg::IDX_MODE_TWO, 8'(m << 2));
			wr(rximd_pkg::IDX_IRQ_MASK, 8'h08);
			FAR.set_ev(6'h00);
			repeat (4) @(negedge aclk);
			wr(rximd_pkg::IDX_IRQ_STAT, 8'hff);
			FAR.set_ev(6'h08);
			repeat (4) @(negedge aclk);
			rd(rximd_pkg::IDX_IRQ_STAT, (m == 1) ? 8'h00 : 8'h08);
			irq_is(m != 1);
			wr(rximd_pkg::IDX_IRQ_STAT, 8'h08);
			FAR.set_ev(6'h00);
			repeat (4) @(negedge aclk);
			rd(rximd_pkg::IDX_IRQ_STAT, (m == 1 || m == 2) ? 8'h08 : 8'h00);
		end
		wr(rximd_pkg::IDX_IRQ_STAT, 8'hff);
		wr(rximd_pkg::IDX_MODE_TWO, 8'h00);
	endtask : t_modes

	task automatic t_all();
		wr(rximd_pkg::IDX_MODE_ONE, 8'h01);
		wr(rximd_pkg::IDX_MODE_TWO, 8'h55);
		wr(rximd_pkg::IDX_MODE_THREE, 8'h01);
		wr(rximd_pkg::IDX_IRQ_MASK, 8'h00);
		FAR.set_ev(6'h3f);
		repeat (4) @(negedge aclk);
		rd(rximd_pkg::IDX_IRQ_STAT, 8'h00);
		FAR.set_ev(6'h00);
		repeat (4) @(negedge aclk);
		rd(rximd_pkg::IDX_IRQ_STAT, 8'h3f);
		irq_is(1'b0);
		wr(rximd_pkg::IDX_IRQ_MASK, 8'h20);
		irq_is(1'b1);
		wr(rximd_pkg::IDX_IRQ_STAT, 8'h3f);
		irq_is(1'b0);
		wr(rximd_pkg::IDX_MODE_ONE, 8'h00);
		wr(rximd_pkg::IDX_MODE_TWO, 8'h00);
		wr(rximd_pkg::IDX_MODE_THREE, 8'h00);
	endtask : t_all

	// Only the selected source moves against all others, so a wrong route shows
	task automatic t_sel();
		for (int c = 0; c < 16; c++) begin
			if (c != 4) begin
				wr(rximd_pkg::IDX_GPO_ONE, 8'(c));
				for (int v = 0; v < 2; v++) begin
					FAR.set_src(v[0] ? hot(c) : ~hot(c));
					repeat (4) @(negedge aclk);
					chk(gp_output_one, pin_exp(c, v[0]));
				end
			end
		end
	endtask : t_sel

	task automatic t_irqpin();
		wr(rximd_pkg::IDX_GPO_ONE, 8'h04);
		repeat (4) @(negedge aclk);
		chk(gp_output_one, 1'b1);
		wr(rximd_pkg::IDX_IRQ_MASK, 8'h01);
		FAR.set_ev(6'h01);
		irq_is(1'b1);
		repeat (4) @(negedge aclk);
		chk(gp_output_one, 1'b0);
		wr(rximd_pkg::IDX_IRQ_STAT, 8'h01);
		irq_is(1'b0);
		repeat (4) @(negedge aclk);
		chk(gp_output_one, 1'b1);
	endtask : t_irqpin

	// A reset in mid-run must bring back the defaults of both outputs, mode one, mode two, the output-one selector and the mask, not only the first one
	task automatic t_rerun();
		wr(rximd_pkg::IDX_GPO_ONE, 8'h01);
		wr(rximd_pkg::IDX_MODE_TWO, 8'haa);
		wr(rximd_pkg::IDX_IRQ_MASK, 8'h3f);
		wr(rximd_pkg::IDX_MODE_ONE, 8'h02);
		irq_is(1'b1);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(gp_output_one, 1'b0);
		chk(rx_irq, 1'b0);
		rd(rximd_pkg::IDX_MODE_ONE, 8'h00);
		rd(rximd_pkg::IDX_MODE_TWO, 8'h00);
		rd(rximd_pkg::IDX_GPO_ONE, 8'h00);
		rd(rximd_pkg::IDX_IRQ_MASK, 8'h00);
	endtask : t_rerun

	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_wstrb = 4'h1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_regs();
		t_modes();
		t_all();
		t_sel();
		t_irqpin();
		t_rerun();
		stop_test();
	end
endmodule : testbench
